/* src/dbdma_cfg.svh */
/*
 Register offsets, field positions and reset values of the DMA block.
 Assumes a 9-bit byte address on the register port.
*/
`ifndef DBDMA_CFG_SVH
`define DBDMA_CFG_SVH

// Word index inside a 0x20-byte channel window
`define DBDMA_OFF_CTL 3'h0
`define DBDMA_OFF_SRC_START 3'h1
`define DBDMA_OFF_DST_START 3'h2
`define DBDMA_OFF_SRC_END 3'h3
`define DBDMA_OFF_DST_END 3'h4
`define DBDMA_OFF_OFS_CNT 3'h5
`define DBDMA_OFF_CUR_SRC 3'h6
`define DBDMA_OFF_CUR_DST 3'h7

// Global registers
`define DBDMA_ADDR_IRQ_STAT 9'h100
`define DBDMA_ADDR_IRQ_CLR 9'h104
`define DBDMA_ADDR_IRQ_EN 9'h108
`define DBDMA_ADDR_PIN_CFG 9'h10c

// Channel control fields
`define DBDMA_CTL_EN 0
`define DBDMA_CTL_CONT 1
`define DBDMA_CTL_CIRC 2
`define DBDMA_CTL_WIDTH 3
`define DBDMA_CTL_REQSEL 5
`define DBDMA_CTL_HWEN 7
`define DBDMA_CTL_SWREQ 8
`define DBDMA_CTL_FLAG 16
`define DBDMA_CTL_PEND 17

// Offset and count fields
`define DBDMA_OFS_SSTEP 0
`define DBDMA_OFS_DSTEP 8
`define DBDMA_OFS_CNT 16

// Pin request unit fields, output k at bit 4*k
`define DBDMA_PIN_SEL 0
`define DBDMA_PIN_EDGE 3

// Reset values
`define DBDMA_RST_CTL 8'h00
`define DBDMA_RST_WORD 32'h0000_0000
`define DBDMA_RST_PIN 8'h00
`define DBDMA_RST_IRQ 8'h00

`endif

/* src/dbdma_pkg.sv */
/*
 Types of the DMA block: engine states and element widths.
 Assumes nothing of its surroundings.
*/
package dbdma_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dbdma_state_t;
  typedef enum logic [1:0] {W_BYTE, W_HALF, W_WORD} dbdma_width_t;
endpackage

/* src/dbdma_chan.sv */
/*
 One DMA channel: register set, request latch and address sequencer.
 Assumes the top decodes the register port and runs the bus engine.
*/
`timescale 1ns/1ps
`include "dbdma_cfg.svh"
module dbdma_chan (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register access
  input wire logic wr_en,
  input wire logic [2:0] wr_off,
  input wire logic [31:0] wdata,
  input wire logic [2:0] rd_off,
  input wire logic flag,
  output logic [31:0] rd_val,
  // Requests and engine handshake
  input wire logic [3:0] hw_req,
  input wire logic grant,
  input wire logic step,
  output logic pend,
  output logic done,
  // Transfer parameters
  output dbdma_pkg::dbdma_width_t width,
  output logic [31:0] cur_src,
  output logic [31:0] cur_dst
);
  logic [7:0] ctl_r;
  logic [31:0] src_st_r, dst_st_r, src_end_r, dst_end_r, ofs_r;
  logic [31:0] cur_src_r, cur_dst_r;
  logic [15:0] cnt_r;
  logic pend_r;

  wire en = ctl_r[`DBDMA_CTL_EN];
  wire cont = ctl_r[`DBDMA_CTL_CONT];
  wire circ = ctl_r[`DBDMA_CTL_CIRC];
  wire ctl_wr = wr_en && (wr_off == `DBDMA_OFF_CTL);
  wire start = ctl_wr && wdata[`DBDMA_CTL_EN] && !en;
  wire last = (cnt_r <= 16'h0001);
  wire [31:0] sstep = {24'h0, ofs_r[`DBDMA_OFS_SSTEP +: 8]};
  wire [31:0] dstep = {24'h0, ofs_r[`DBDMA_OFS_DSTEP +: 8]};
  wire hw_sel = hw_req[ctl_r[`DBDMA_CTL_REQSEL +: 2]];
  wire sw_req = ctl_wr && wdata[`DBDMA_CTL_SWREQ];
  wire req_in = (en && ctl_r[`DBDMA_CTL_HWEN] && hw_sel) || sw_req;
  // Wrap at the end address back to the start address
  wire src_wrap = circ && (cur_src_r == src_end_r);
  wire dst_wrap = circ && (cur_dst_r == dst_end_r);
  wire [31:0] src_nxt = src_wrap ? src_st_r : cur_src_r + sstep;
  wire [31:0] dst_nxt = dst_wrap ? dst_st_r : cur_dst_r + dstep;
  wire reload = start || (done && cont);

  assign done = step && last;
  assign pend = pend_r && en;
  assign width = dbdma_pkg::dbdma_width_t'(ctl_r[`DBDMA_CTL_WIDTH +: 2]);
  assign cur_src = cur_src_r;
  assign cur_dst = cur_dst_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctl_r <= `DBDMA_RST_CTL;
    end else if (ctl_wr) begin
      ctl_r <= wdata[7:0];
    end else if (done && !cont) begin
      ctl_r[`DBDMA_CTL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      src_st_r <= `DBDMA_RST_WORD;
      dst_st_r <= `DBDMA_RST_WORD;
      src_end_r <= `DBDMA_RST_WORD;
      dst_end_r <= `DBDMA_RST_WORD;
      ofs_r <= `DBDMA_RST_WORD;
    end else if (wr_en) begin
      case (wr_off)
        `DBDMA_OFF_SRC_START: src_st_r <= wdata;
        `DBDMA_OFF_DST_START: dst_st_r <= wdata;
        `DBDMA_OFF_SRC_END: src_end_r <= wdata;
        `DBDMA_OFF_DST_END: dst_end_r <= wdata;
        `DBDMA_OFF_OFS_CNT: ofs_r <= wdata;
        default: ;
      endcase
    end
  end

  // Continuous mode restarts the whole transaction from the start set
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur_src_r <= `DBDMA_RST_WORD;
      cur_dst_r <= `DBDMA_RST_WORD;
      cnt_r <= 16'h0000;
    end else if (reload) begin
      cur_src_r <= src_st_r;
      cur_dst_r <= dst_st_r;
      cnt_r <= ofs_r[`DBDMA_OFS_CNT +: 16];
    end else if (step) begin
      cur_src_r <= src_nxt;
      cur_dst_r <= dst_nxt;
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // A new request wins over the grant that clears the latch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (req_in) begin
      pend_r <= 1'b1;
    end else if (grant || !en) begin
      pend_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (rd_off)
      `DBDMA_OFF_CTL: rd_val = {14'h0, pend, flag, 8'h00, ctl_r};
      `DBDMA_OFF_SRC_START: rd_val = src_st_r;
      `DBDMA_OFF_DST_START: rd_val = dst_st_r;
      `DBDMA_OFF_SRC_END: rd_val = src_end_r;
      `DBDMA_OFF_DST_END: rd_val = dst_end_r;
      `DBDMA_OFF_OFS_CNT: rd_val = ofs_r;
      `DBDMA_OFF_CUR_SRC: rd_val = cur_src_r;
      `DBDMA_OFF_CUR_DST: rd_val = cur_dst_r;
    endcase
  end

  AST_SINGLE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      done && !cont && !ctl_wr |=> !en)
    else $error("single mode channel still enabled after last transfer");
  AST_CONT:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      done && cont && !ctl_wr |=> en && cnt_r == $past(ofs_r[31:16]))
    else $error("continuous channel did not stay enabled and reload");
  AST_CIRC:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      step && !reload && src_wrap |=> cur_src_r == $past(src_st_r))
    else $error("circular source did not wrap to start address");
  AST_STEP:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      step && !reload && !dst_wrap
      |=> cur_dst_r == $past(cur_dst_r) + $past(dstep))
    else $error("destination did not advance by its step");
  AST_SW:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      sw_req && wdata[`DBDMA_CTL_EN] |=> pend)
    else $error("software request not pending");
endmodule

/* src/dbdma_top.sv */
/*
 Two-block, eight-channel DMA controller with a pin request unit,
 a register port, an interrupt and one bus master port.
 Assumes request inputs come from logic on sys_clk, pin inputs from
 outside, and a bus slave that answers each master access with m_ack.
*/
// The address-and-strobe port and the register offsets were decided locally.
// Contract
// - Eight channels, in two blocks of four.
// - Each block has sixteen request inputs; four feed each channel.
// - Each channel picks its trigger among four request inputs.
// - Pending channels of one block are granted by fixed priority.
// - A transfer starts on a hardware or a software request.
// - Pin unit routes two of eight pin inputs to two request outputs.
// - Each routed pin is taken as rising edge or as level.
// - Single mode clears the enable after the last transfer.
// - Continuous mode keeps the enable and repeats the transaction.
// - Source and destination addresses are full 32 bits.
// - After a transfer each address advances by its 0..255 step.
// - Each channel offers circular buffer addressing.
// - Elements are bytes, halfwords or words.
// - Each channel has start, end, control and offset/count registers.
// - The controller masters the bus for source read and dest write.
// - One channel owns each transfer from source to destination.
`timescale 1ns/1ps
`include "dbdma_cfg.svh"
module dbdma_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Hardware request inputs
  input wire logic [15:0] blk0_req,
  input wire logic [15:0] blk1_req,
  // Pin request unit
  input wire logic [7:0] pin_req_in,
  output logic [1:0] pin_req_out,
  // Bus master
  output logic m_req,
  output logic m_we,
  output logic [31:0] m_addr,
  output dbdma_pkg::dbdma_width_t m_size,
  output logic [31:0] m_wdata,
  input wire logic [31:0] m_rdata,
  input wire logic m_ack,
  // Interrupt
  output logic irq
);
  dbdma_pkg::dbdma_state_t state_r;
  logic [2:0] sel_r;
  logic turn_r;
  logic m_req_r, m_we_r;
  logic [31:0] m_addr_r, m_wdata_r, rdata_r;
  dbdma_pkg::dbdma_width_t m_size_r;
  logic [7:0] st_r, ien_r, pin_cfg_r;
  logic irq_r;
  logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [1:0] pin_out_r, pin_nxt;
  logic [7:0] st_nxt, ien_nxt;

  logic [31:0] rd_val_w [8];
  logic [31:0] cur_src_w [8];
  logic [31:0] cur_dst_w [8];
  dbdma_pkg::dbdma_width_t width_w [8];
  logic [7:0] pend_w, done_w, grant_w, step_w, wr_w;

  // Register decode
  wire [8:0] word_addr = {reg_addr[8:2], 2'h0};
  wire glob = reg_addr[8];
  wire [2:0] ch_idx = reg_addr[7:5];
  wire [2:0] ch_off = reg_addr[4:2];
  wire wr_clr = reg_wr && (word_addr == `DBDMA_ADDR_IRQ_CLR);
  wire wr_ien = reg_wr && (word_addr == `DBDMA_ADDR_IRQ_EN);
  wire wr_pin = reg_wr && (word_addr == `DBDMA_ADDR_PIN_CFG);
  wire [31:0] glob_val =
    (word_addr == `DBDMA_ADDR_IRQ_STAT) ? {24'h0, st_r} :
    (word_addr == `DBDMA_ADDR_IRQ_EN) ? {24'h0, ien_r} :
    (word_addr == `DBDMA_ADDR_PIN_CFG) ? {24'h0, pin_cfg_r} :
    32'h0000_0000;
  wire [31:0] rd_nxt = glob ? glob_val : rd_val_w[ch_idx];

  // Fixed priority inside each block, blocks take turns
  wire [3:0] p0 = pend_w[3:0];
  wire [3:0] p1 = pend_w[7:4];
  wire [1:0] lo0 = p0[0] ? 2'h0 : p0[1] ? 2'h1 : p0[2] ? 2'h2 : 2'h3;
  wire [1:0] lo1 = p1[0] ? 2'h0 : p1[1] ? 2'h1 : p1[2] ? 2'h2 : 2'h3;
  wire use1 = (|p1) && (turn_r || !(|p0));
  wire [2:0] pick = use1 ? {1'b1, lo1} : {1'b0, lo0};
  wire idle = (state_r == dbdma_pkg::ST_IDLE);
  wire go = idle && (|pend_w);
  wire rd_ack = (state_r == dbdma_pkg::ST_RD) && m_ack;
  wire wr_ack = (state_r == dbdma_pkg::ST_WR) && m_ack;
  wire [31:0] src_pick = cur_src_w[pick];
  wire [31:0] all_req = {blk1_req, blk0_req};

  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_ch
      assign wr_w[c] = reg_wr && !glob && (ch_idx == 3'(c));
      assign grant_w[c] = go && (pick == 3'(c));
      assign step_w[c] = wr_ack && (sel_r == 3'(c));
      dbdma_chan u_chan (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_w[c]),
        .wr_off(ch_off),
        .wdata(reg_wdata),
        .rd_off(ch_off),
        .flag(st_r[c]),
        .rd_val(rd_val_w[c]),
        .hw_req(all_req[4*c +: 4]),
        .grant(grant_w[c]),
        .step(step_w[c]),
        .pend(pend_w[c]),
        .done(done_w[c]),
        .width(width_w[c]),
        .cur_src(cur_src_w[c]),
        .cur_dst(cur_dst_w[c])
      );
    end
  endgenerate

  // Transfer engine: read the source, then write the destination
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= dbdma_pkg::ST_IDLE;
      sel_r <= 3'h0;
      turn_r <= 1'b0;
    end else begin
      unique case (state_r)
        dbdma_pkg::ST_IDLE: begin
          if (go) begin
            state_r <= dbdma_pkg::ST_RD;
            sel_r <= pick;
            turn_r <= !pick[2];
          end
        end
        dbdma_pkg::ST_RD: begin
          if (m_ack) begin
            state_r <= dbdma_pkg::ST_WR;
          end
        end
        dbdma_pkg::ST_WR: begin
          if (m_ack) begin
            state_r <= dbdma_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Master port; the read element is passed through in its own lane
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      m_req_r <= 1'b0;
      m_we_r <= 1'b0;
      m_addr_r <= `DBDMA_RST_WORD;
      m_wdata_r <= `DBDMA_RST_WORD;
      m_size_r <= dbdma_pkg::W_BYTE;
    end else if (go) begin
      m_req_r <= 1'b1;
      m_we_r <= 1'b0;
      m_addr_r <= src_pick;
      m_size_r <= width_w[pick];
    end else if (rd_ack) begin
      m_we_r <= 1'b1;
      m_addr_r <= cur_dst_w[sel_r];
      m_wdata_r <= m_rdata;
    end else if (wr_ack) begin
      m_req_r <= 1'b0;
      m_we_r <= 1'b0;
    end
  end

  // Interrupt: set wins over clear
  assign st_nxt = (st_r & ~(wr_clr ? reg_wdata[7:0] : 8'h00)) | done_w;
  assign ien_nxt = wr_ien ? reg_wdata[7:0] : ien_r;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= `DBDMA_RST_IRQ;
      ien_r <= `DBDMA_RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ien_r <= ien_nxt;
      irq_r <= |(st_nxt & ien_nxt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_r <= `DBDMA_RST_WORD;
      pin_cfg_r <= `DBDMA_RST_PIN;
    end else begin
      rdata_r <= reg_rd ? rd_nxt : 32'h0000_0000;
      if (wr_pin) begin
        pin_cfg_r <= reg_wdata[7:0];
      end
    end
  end

  // Pin request unit; a change of selection may look like one edge
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_pin
      wire [2:0] psel = pin_cfg_r[4*k + `DBDMA_PIN_SEL +: 3];
      wire pedge = pin_cfg_r[4*k + `DBDMA_PIN_EDGE];
      wire plvl = pin_s2_r[psel];
      wire prise = pin_s2_r[psel] && !pin_s3_r[psel];
      assign pin_nxt[k] = pedge ? prise : plvl;
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_s3_r <= 8'h00;
      pin_out_r <= 2'h0;
    end else begin
      pin_s1_r <= pin_req_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_out_r <= pin_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pin_req_out = pin_out_r;
  assign m_req = m_req_r;
  assign m_we = m_we_r;
  assign m_addr = m_addr_r;
  assign m_size = m_size_r;
  assign m_wdata = m_wdata_r;
  assign irq = irq_r;

  // Pairing tracker: one write closes each source read
  logic rd_open_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_open_r <= 1'b0;
    end else if (rd_ack) begin
      rd_open_r <= 1'b1;
    end else if (wr_ack) begin
      rd_open_r <= 1'b0;
    end
  end

  AST_PRIO:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      go |-> ((pick[2] ? p1 : p0)
        & ((4'h1 << pick[1:0]) - 4'h1)) == 4'h0)
    else $error("a lower numbered pending channel was passed over");
  AST_SRC:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      go |=> m_req_r && !m_we_r && m_addr_r == $past(src_pick))
    else $error("source read not issued at granted address");
  AST_DST:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_ack |=> m_we_r && m_addr_r == $past(cur_dst_w[sel_r])
        && m_wdata_r == $past(m_rdata))
    else $error("destination write does not follow the source read");
  AST_HOLD:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      m_req_r && !m_ack |=> m_req_r && $stable(m_addr_r) && $stable(sel_r))
    else $error("master access dropped before acknowledge");
  AST_FLAG:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      (|done_w) |=> (st_r & $past(done_w)) == $past(done_w))
    else $error("count expiry did not set the service flag");
  AST_PINLVL:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      !pin_cfg_r[3] |=> pin_out_r[0] == $past(pin_s2_r[pin_cfg_r[2:0]]))
    else $error("level-mode pin request does not follow the pin");
  AST_PINEDGE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      pin_cfg_r[3] && pin_s2_r[pin_cfg_r[2:0]]
        && pin_s3_r[pin_cfg_r[2:0]] |=> !pin_out_r[0])
    else $error("edge-mode pin request repeated on a held level");

  // Engine, pairing and master port checks
  AST_SIZE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      go |=> m_size_r == $past(width_w[pick]))
    else $error("element width not taken from the granted channel");
  AST_ONEOWN:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_ack |-> step_w == (8'h01 << sel_r))
    else $error("a write step reached a channel that does not own it");
  AST_IDLE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      idle == !m_req_r)
    else $error("master request and engine state disagree");
  AST_WRPHASE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      m_we_r |-> state_r == dbdma_pkg::ST_WR)
    else $error("destination write outside the write phase");
  AST_ALT:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      go && (|p0) && (|p1) |-> pick[2] == turn_r)
    else $error("blocks did not take turns while both pending");
  AST_PAIR_RD:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_ack |-> !rd_open_r)
    else $error("second source read before the destination write");
  AST_PAIR_WR:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_ack |-> rd_open_r)
    else $error("destination write without a source read");

  // Status, interrupt and read port checks
  AST_IRQ:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      irq_r == |(st_r & ien_r))
    else $error("interrupt level does not match enabled status");
  AST_CLR:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_clr && !(|done_w) |=> (st_r & $past(reg_wdata[7:0])) == 8'h00)
    else $error("status bit survived its clear");
  AST_RDIDLE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data present without a read");
  AST_RDSTAT:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && (word_addr == `DBDMA_ADDR_IRQ_STAT)
      |=> reg_rdata == {24'h00_0000, $past(st_r)})
    else $error("status read does not return the service flags");

  // A changed selection may fake one edge, so only a stable one counts
  AST_PINPULSE:
    assert property (@(posedge sys_clk) disable iff (!rstn)
      pin_cfg_r[7] && pin_out_r[1] && $stable(pin_cfg_r)
      |=> !pin_out_r[1])
    else $error("edge-mode pin request lasted more than one cycle");

  COV_XFER: cover property (@(posedge sys_clk) disable iff (!rstn)
    rd_ack ##1 !m_ack [*1] ##[0:20] wr_ack);
  COV_BOTH: cover property (@(posedge sys_clk) disable iff (!rstn)
    go && (|p0) && (|p1));
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rstn)
    !irq_r ##1 irq_r);
  COV_PIN: cover property (@(posedge sys_clk) disable iff (!rstn)
    pin_cfg_r[7] && pin_out_r[1]);
  COV_BLK1: cover property (@(posedge sys_clk) disable iff (!rstn)
    go && pick[2]);
endmodule

/* testbench/dbdma_slave_model.sv */
/*
 Bus slave model for the DMA master port, answering with m_ack.
 Assumes the master holds its request until acknowledged.
*/
`timescale 1ns/1ps
module dbdma_slave_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus slave side
  input wire logic m_req,
  input wire logic m_we,
  input wire logic [31:0] m_addr,
  output logic [31:0] m_rdata,
  output logic m_ack,
  // Wait states before each answer
  input wire logic [3:0] wait_cyc
);
  logic [3:0] cnt_r;
  logic [31:0] last_r;
  // Read data is the inverted address, so copies are traceable
  // Idle bus shows the inverse of the last word, never a stale copy
  assign m_rdata = (m_ack && !m_we) ? ~m_addr : ~last_r;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      m_ack <= 1'b0;
      cnt_r <= 4'h0;
      last_r <= 32'h0000_0000;
    end else if (m_ack) begin
      m_ack <= 1'b0;
      cnt_r <= 4'h0;
      if (!m_we) begin
        last_r <= ~m_addr;
      end
    end else if (m_req) begin
      if (cnt_r >= wait_cyc) begin
        m_ack <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

/* testbench/testbench.sv */
/*
 Self-checking bench for the DMA controller top.
 Assumes the slave model on the master port and one 10 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
  logic sys_clk, rstn, reg_wr, reg_rd, m_req, m_we, m_ack, irq;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m_addr, m_wdata, m_rdata;
  logic [15:0] blk0_req, blk1_req;
  logic [7:0] pin_req_in;
  logic [1:0] pin_req_out;
  logic [3:0] wait_cyc;
  logic [31:0] rd_a, wr_a, wr_d;
  dbdma_pkg::dbdma_width_t m_size, rd_sz;
  int nwr, err_total, checks;

  dbdma_top dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .blk0_req(blk0_req), .blk1_req(blk1_req),
    .pin_req_in(pin_req_in), .pin_req_out(pin_req_out), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata),
    .m_rdata(m_rdata), .m_ack(m_ack), .irq(irq));
  dbdma_slave_model slave (.sys_clk(sys_clk), .rstn(rstn), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_rdata(m_rdata), .m_ack(m_ack),
    .wait_cyc(wait_cyc));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Log of the last read and write seen on the master port
  always @(posedge sys_clk) begin
    if (m_req && m_ack && !m_we) begin
      rd_a <= m_addr;
      rd_sz <= m_size;
    end
    if (m_req && m_ack && m_we) begin
      wr_a <= m_addr;
      wr_d <= m_wdata;
      nwr <= nwr + 1;
    end
  end

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask

  // Bounded wait for n more destination writes
  task automatic xw(input int n);
    int t;
    t = nwr + n;
    for (int i = 0; i < 3000 && nwr < t; i++) @(posedge sys_clk);
    `CHK(nwr, t)
  endtask

  task automatic cfg(input logic [8:0] b, input logic [31:0] s, d, oc,
                     ctl);
    wr(b + 9'h4, s);
    wr(b + 9'h8, d);
    wr(b + 9'hc, 32'hffff_fff0);
    wr(b + 9'h10, 32'hffff_fff0);
    wr(b + 9'h14, oc);
    wr(b, ctl);
  endtask

  task automatic t_reset;
    logic [31:0] v;
    rd(9'h1f0, v);
    `CHK(v, 32'h0000_0000)
    rd(9'h060, v);
    `CHK(v, 32'h0000_0000)
    rd(9'h10c, v);
    `CHK(v, 32'h0000_0000)
    `CHK(irq, 1'b0)
  endtask

  // Software requests, single mode, all three widths
  task automatic t_single;
    logic [31:0] v, s, d;
    s = 32'hf000_0100;
    d = 32'h8000_0200;
    for (int w = 0; w < 3; w++) begin
      cfg(9'h000, s, d, 32'h0002_10ff, 32'(1 + w * 8));
      wr(9'h000, 32'(1 + w * 8 + 256));
      xw(1);
      `CHK(rd_a, s)
      `CHK(wr_a, d)
      `CHK(wr_d, ~s)
      `CHK(rd_sz, dbdma_pkg::dbdma_width_t'(w))
      wr(9'h000, 32'(1 + w * 8 + 256));
      xw(1);
      `CHK(rd_a, s + 32'd255)
      `CHK(wr_a, d + 32'h10)
      rd(9'h000, v);
      `CHK(v[7:0], 8'(w * 8))
      `CHK(v[16], 1'b1)
      `CHK(irq, w != 0)
      if (w == 0) begin
        rd(9'h100, v);
        `CHK(v[7:0], 8'h01)
        wr(9'h108, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1)
      end
      wr(9'h104, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'b0)
    end
  endtask

  // Channel 5: continuous, circular, hardware input 6, slow slave
  task automatic t_circ;
    logic [31:0] v;
    int n0;
    wait_cyc <= 4'h3;
    cfg(9'h0a0, 32'h40, 32'h80, 32'h0004_0404, 32'h0000_00d7);
    wr(9'h0ac, 32'h44);
    wr(9'h0b0, 32'h88);
    for (int i = 0; i < 4; i++) begin
      blk1_req[6] <= 1'b1;
      @(posedge sys_clk);
      blk1_req[6] <= 1'b0;
      xw(1);
      `CHK(rd_a, 32'h40 + 32'(i % 2 * 4))
      `CHK(wr_a, 32'h80 + 32'(i % 3 * 4))
    end
    n0 = nwr;
    blk1_req[5] <= 1'b1;
    @(posedge sys_clk);
    blk1_req[5] <= 1'b0;
    repeat (20) @(posedge sys_clk);
    `CHK(nwr, n0)
    rd(9'h0a0, v);
    `CHK(v[7:0], 8'hd7)
    wr(9'h0a0, 32'h0000_0000);
    wr(9'h104, 32'h0000_00ff);
  endtask

  // Channels 1 and 2 pend together; order must repeat each round
  task automatic t_prio;
    wait_cyc <= 4'h1;
    for (int r = 0; r < 2; r++) begin
      cfg(9'h020, 32'h100, 32'h180, 32'h0001_0000, 32'h0000_00e1);
      cfg(9'h040, 32'h200, 32'h280, 32'h0001_0000, 32'h0000_0081);
      blk0_req[7] <= 1'b1;
      blk0_req[8] <= 1'b1;
      @(posedge sys_clk);
      blk0_req[7] <= 1'b0;
      blk0_req[8] <= 1'b0;
      xw(1);
      `CHK(rd_a, 32'h100)
      xw(1);
      `CHK(rd_a, 32'h200)
    end
    wr(9'h104, 32'h0000_00ff);
  endtask

  // Pin 3 level and pin 5 edge, then the two outputs swap roles
  task automatic t_pin;
    logic [31:0] v;
    int n0, n1;
    for (int p = 0; p < 2; p++) begin
      n0 = 0;
      n1 = 0;
      wr(9'h10c, p == 0 ? 32'h0000_00d3 : 32'h0000_003d);
      rd(9'h10c, v);
      `CHK(v, p == 0 ? 32'h0000_00d3 : 32'h0000_003d)
      pin_req_in <= 8'h29;
      for (int i = 0; i < 16; i++) begin
        @(posedge sys_clk);
        if (i == 5) pin_req_in <= 8'h00;
        #1;
        n0 += pin_req_out[0];
        n1 += pin_req_out[1];
      end
      `CHK(n0, p == 0 ? 6 : 1)
      `CHK(n1, p == 0 ? 1 : 6)
    end
  endtask

  task automatic conclude;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    blk0_req = 16'h0000;
    blk1_req = 16'h0000;
    pin_req_in = 8'h00;
    wait_cyc = 4'h0;
    nwr = 0;
    err_total = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_single;
    t_circ;
    t_prio;
    t_pin;
    conclude;
  end

  // Whole run needs a few hundred cycles; allow 20000
  initial begin
    #2000000;
    err_total++;
    conclude;
  end
endmodule
